/* File: core/rgbps_pkg.sv */
// Shared constants, types and decode helpers of the RGB pattern sequencer.
package rgbps_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned PS_PER_MS      = 1000000000;
  localparam int unsigned CYC_PER_MS_DEF = PS_PER_MS / CLK_PERIOD_PS;

  // ==========================================================================
  // Register map, as word indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] CTRL_IDX      = 8'h11;
  localparam logic [7:0] STAT_IDX      = 8'h20;
  localparam logic [7:0] CMD_IDX_FIRST = 8'h50;
  localparam logic [7:0] CMD_IDX_LAST  = 8'h5f;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CMD_RESET     = 8'h00;
  localparam int CTRL_RUN_BIT   = 2;
  localparam int CTRL_LOOP_BIT  = 1;
  localparam int CTRL_CURVE_BIT = 0;
  localparam int STAT_BUSY_BIT  = 4;
  localparam int STAT_DONE_BIT  = 3;

  // ==========================================================================
  // Command word layout: first byte in [15:8], second byte in [7:0]
  // ==========================================================================
  localparam int CMD_NUM   = 8;
  localparam int CMD_BYTES = 16;
  localparam int CMD_RED_LSB  = 13;
  localparam int CMD_GRN_LSB  = 10;
  localparam int CMD_STEP_LSB = 6;
  localparam int CMD_BLU_LSB  = 3;
  localparam int CMD_FADE_LSB = 0;

  // ==========================================================================
  // Step and fade durations in milliseconds
  // ==========================================================================
  localparam int unsigned STEP_MS_MIN   = 197;
  localparam int unsigned STEP_MS_MAX   = 3146;
  localparam int unsigned STEP_CODE_MAX = 15;
  typedef logic [11:0] rgbps_ms_t;
  localparam rgbps_ms_t FADE_MS [8] = '{12'd0, 12'd55, 12'd110, 12'd221,
                                        12'd442, 12'd885, 12'd1770, 12'd3539};
  localparam int PHASE_SHIFT = 7;
  localparam logic [7:0] PHASE_FULL = 8'h80;

  // ==========================================================================
  // Types and intensity curves
  // ==========================================================================
  typedef logic [6:0]  rgbps_pct_t;
  typedef logic [15:0] rgbps_cmd_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} rgbps_state_t;

  localparam rgbps_pct_t CURVE0 [8] = '{7'h00, 7'h07, 7'h0e, 7'h15,
                                        7'h20, 7'h2e, 7'h47, 7'h64};
  localparam rgbps_pct_t CURVE1 [8] = '{7'h00, 7'h01, 7'h02, 7'h04,
                                        7'h0a, 7'h15, 7'h2e, 7'h64};

  // Maps a 3-bit level to percent of full current on the chosen curve.
  function automatic rgbps_pct_t rgbps_curve(logic [2:0] lvl, logic sel);
    return sel ? CURVE1[lvl] : CURVE0[lvl];
  endfunction : rgbps_curve

endpackage : rgbps_pkg

/* File: core/rgbps_tmr_if.sv */
// Carrier between the sequencer and its step and fade timer.
`timescale 1ns/10ps
interface rgbps_tmr_if;
  logic       start;
  logic [3:0] step_code;
  logic [2:0] fade_code;
  logic       step_done;
  logic [7:0] phase;

  modport seq   (output start, step_code, fade_code, input step_done, phase);
  modport timer (input start, step_code, fade_code, output step_done, phase);
endinterface : rgbps_tmr_if

/* File: core/rgbps_timer.sv */
// Step hold timer and fade phase generator of the pattern sequencer.
`timescale 1ns/10ps
module rgbps_timer #(
  parameter int unsigned CYC_PER_MS = rgbps_pkg::CYC_PER_MS_DEF
) (
  // Clock, reset, enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Sequencer side.
  rgbps_tmr_if.timer tmr
);
  import rgbps_pkg::*;

  logic [31:0] step_cnt_reg, step_cnt_next;
  logic [31:0] step_len_reg, step_len_next;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [31:0] tick_len_reg, tick_len_next;
  logic [7:0]  phase_reg,    phase_next;
  logic        done_reg,     done_next;

  // Last cycle index of a step; linear in the code, ends land exactly.
  function automatic logic [31:0] step_last(logic [3:0] code);
    int unsigned ms;
    ms = STEP_MS_MIN + (int'(code) * (STEP_MS_MAX - STEP_MS_MIN))
         / STEP_CODE_MAX;
    return 32'(ms * CYC_PER_MS) - 32'h1;
  endfunction : step_last

  // Cycles per phase increment; never zero so short benches still fade.
  function automatic logic [31:0] tick_last(logic [2:0] code);
    int unsigned cyc;
    cyc = (int'(FADE_MS[code]) * CYC_PER_MS) >> PHASE_SHIFT;
    return (cyc == 0) ? 32'h0 : 32'(cyc) - 32'h1;
  endfunction : tick_last

  // Hold and fade run side by side, so a step shorter than its fade is
  // simply cut off by the next start.
  always_comb
  begin
    step_cnt_next = step_cnt_reg;
    step_len_next = step_len_reg;
    tick_cnt_next = tick_cnt_reg;
    tick_len_next = tick_len_reg;
    phase_next    = phase_reg;
    done_next     = 1'b0;
    if (tmr.start)
    begin
      step_cnt_next = 32'h0;
      step_len_next = step_last(tmr.step_code);
      tick_cnt_next = 32'h0;
      tick_len_next = tick_last(tmr.fade_code);
      phase_next    = (tmr.fade_code == 3'h0) ? PHASE_FULL : 8'h00;
    end
    else
    begin
      done_next     = (step_cnt_reg == step_len_reg);
      step_cnt_next = done_next ? 32'h0 : step_cnt_reg + 32'h1;
      if (phase_reg != PHASE_FULL)
      begin
        if (tick_cnt_reg == tick_len_reg)
        begin
          tick_cnt_next = 32'h0;
          phase_next    = phase_reg + 8'h01;
        end
        else
          tick_cnt_next = tick_cnt_reg + 32'h1;
      end
    end
  end

  // Registers; everything freezes while the enable is low.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      step_cnt_reg <= 32'h0;
      step_len_reg <= 32'h0;
      tick_cnt_reg <= 32'h0;
      tick_len_reg <= 32'h0;
      phase_reg    <= PHASE_FULL;
      done_reg     <= 1'b0;
    end
    else if (ce)
    begin
      step_cnt_reg <= step_cnt_next;
      step_len_reg <= step_len_next;
      tick_cnt_reg <= tick_cnt_next;
      tick_len_reg <= tick_len_next;
      phase_reg    <= phase_next;
      done_reg     <= done_next;
    end
  end

  assign tmr.step_done = done_reg;
  assign tmr.phase     = phase_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  fade_zero_a: assert property (@(posedge clk) disable iff (srst || !ce)
    tmr.start && tmr.fade_code == 3'h0 |=> phase_reg == PHASE_FULL)
    else $error("zero fade code did not complete at once");
  fade_mono_a: assert property (@(posedge clk) disable iff (srst || !ce)
    !tmr.start |=> phase_reg >= $past(phase_reg))
    else $error("fade phase went backwards without a start");

endmodule : rgbps_timer

/* File: core/rgbps_top.sv */
// APB register file and command sequencer for one RGB LED set.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps

module rgbps_top #(
  parameter int unsigned CYC_PER_MS = rgbps_pkg::CYC_PER_MS_DEF,
  parameter int          ADDR_W     = 12
) (
  // Clock, reset, enable.
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               ce,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // LED intensities in percent of full current, and the busy flag.
  output rgbps_pkg::rgbps_pct_t   red_pct,
  output rgbps_pkg::rgbps_pct_t   green_pct,
  output rgbps_pkg::rgbps_pct_t   blue_pct,
  output logic                    seq_busy
);
  import rgbps_pkg::*;

  // ==========================================================================
  // Declarations
  rgbps_tmr_if tmr ();
  logic [7:0]   ctrl_reg,     ctrl_next;
  logic [7:0]   cmd_mem_reg   [CMD_BYTES];
  logic [7:0]   cmd_mem_next  [CMD_BYTES];
  logic [31:0]  prdata_reg,   prdata_next;
  logic         pready_reg,   pready_next;
  logic         pslverr_reg,  pslverr_next;
  rgbps_state_t state_reg,    state_next;
  logic [2:0]   ptr_reg,      ptr_next;
  logic         run_prev_reg, run_prev_next;
  logic         start_reg,    start_next;
  logic [3:0]   step_code_reg, step_code_next;
  logic [2:0]   fade_code_reg, fade_code_next;
  rgbps_cmd_t   shadow_reg    [CMD_NUM];
  rgbps_cmd_t   shadow_next   [CMD_NUM];
  rgbps_pct_t   prev_reg      [3];
  rgbps_pct_t   prev_next     [3];
  rgbps_pct_t   target_reg    [3];
  rgbps_pct_t   target_next   [3];
  rgbps_pct_t   led_reg       [3];
  rgbps_pct_t   led_next      [3];
  rgbps_cmd_t   fresh_word    [CMD_NUM];
  logic [7:0]   idx;
  logic         wr_done, run, start_evt, busy_reg, busy_next;
  // True for any index that holds a command byte.
  function automatic logic is_cmd(logic [7:0] i);
    return (i >= CMD_IDX_FIRST) && (i <= CMD_IDX_LAST);
  endfunction : is_cmd

  // Linear mix from a to b; phase full scale lands exactly on b.
  function automatic rgbps_pct_t fade_mix(rgbps_pct_t a, rgbps_pct_t b,
                                          logic [7:0] ph);
    logic signed [8:0]  diff;
    logic signed [17:0] prod;
    logic signed [10:0] sum;
    diff = $signed({2'h0, b}) - $signed({2'h0, a});
    prod = diff * $signed({1'b0, ph});
    sum  = $signed({4'h0, a}) + $signed(prod[17:PHASE_SHIFT]);
    return sum[6:0];
  endfunction : fade_mix

  // ==========================================================================
  // Command timer
  rgbps_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .tmr  (tmr.timer)
  );

  assign tmr.start     = start_reg;
  assign tmr.step_code = step_code_reg;
  assign tmr.fade_code = fade_code_reg;

  // Command words as seen in the byte registers, first byte high.
  for (genvar k = 0; k < CMD_NUM; k++)
  begin : g_fresh
    assign fresh_word[k] = {cmd_mem_reg[2*k], cmd_mem_reg[2*k+1]};
  end

  // ==========================================================================
  // APB slave: one wait state, then the answer with pready
  assign idx     = paddr[9:2];
  assign wr_done = psel && penable && pready_reg && pwrite && !pslverr_reg;

  // Decode is latched with the answer so the write edge only checks it.
  always_comb
  begin
    ctrl_next    = ctrl_reg;
    cmd_mem_next = cmd_mem_reg;
    pready_next  = psel && penable && !pready_reg;
    prdata_next  = 32'h0;
    pslverr_next = 1'b0;
    if (pready_next)
    begin
      if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != '0)
        pslverr_next = 1'b1;
      else if (idx == CTRL_IDX)
        prdata_next = {24'h0, ctrl_reg};
      else if (is_cmd(idx))
        prdata_next = {24'h0, cmd_mem_reg[idx[3:0]]};
      else if (idx == STAT_IDX && !pwrite)
        prdata_next = {27'h0, state_reg == SEQ_RUN,
                       state_reg == SEQ_DONE, ptr_reg};
      else
        pslverr_next = 1'b1;
    end
    if (wr_done && idx == CTRL_IDX)
      ctrl_next = pwdata[7:0];
    if (wr_done && is_cmd(idx))
      cmd_mem_next[idx[3:0]] = pwdata[7:0];
  end

  // APB and register storage.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_reg    <= CTRL_RESET;
      cmd_mem_reg <= '{default: CMD_RESET};
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_reg    <= ctrl_next;
      cmd_mem_reg <= cmd_mem_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // Sequencer
  assign run       = ctrl_reg[CTRL_RUN_BIT];
  assign start_evt = run && !run_prev_reg;

  // Steps through the latched copy; commands only reach the LEDs through a
  // load, so a finished pass cannot be disturbed by later writes.
  always_comb
  begin
    logic       load_now, relatch;
    logic [2:0] load_ptr;
    rgbps_cmd_t word;
    load_now       = 1'b0;
    relatch        = 1'b0;
    load_ptr       = 3'h0;
    word           = 16'h0000;
    state_next     = state_reg;
    ptr_next       = ptr_reg;
    run_prev_next  = run;
    start_next     = 1'b0;
    step_code_next = step_code_reg;
    fade_code_next = fade_code_reg;
    shadow_next    = shadow_reg;
    prev_next      = prev_reg;
    target_next    = target_reg;
    led_next       = led_reg;
    case (state_reg)
      SEQ_IDLE:
      begin
        load_now = start_evt;
        relatch  = start_evt;
      end
      SEQ_RUN:
      begin
        // The cycle of a start still sees the old phase, so hold then.
        if (!start_reg)
          for (int c = 0; c < 3; c++)
            led_next[c] = fade_mix(prev_reg[c], target_reg[c], tmr.phase);
        if (tmr.step_done && !start_reg)
        begin
          if (ptr_reg == 3'(CMD_NUM - 1) ||
              shadow_reg[ptr_reg + 3'h1] == 16'h0000)
          begin
            if (ctrl_reg[CTRL_LOOP_BIT])
            begin
              load_now = 1'b1;
              relatch  = 1'b1;
            end
            else
              state_next = SEQ_DONE;
          end
          else
          begin
            load_now = 1'b1;
            load_ptr = ptr_reg + 3'h1;
          end
        end
      end
      SEQ_DONE:
        state_next = SEQ_DONE;
      default:
        state_next = SEQ_IDLE;
    endcase
    if (load_now)
    begin
      if (relatch)
        shadow_next = fresh_word;
      word = relatch ? fresh_word[load_ptr] : shadow_reg[load_ptr];
      if (word == 16'h0000)
        state_next = SEQ_DONE;
      else
      begin
        state_next     = SEQ_RUN;
        ptr_next       = load_ptr;
        start_next     = 1'b1;
        step_code_next = word[CMD_STEP_LSB +: 4];
        fade_code_next = word[CMD_FADE_LSB +: 3];
        prev_next      = led_next;
        target_next[0] = rgbps_curve(word[CMD_RED_LSB +: 3],
                                     ctrl_reg[CTRL_CURVE_BIT]);
        target_next[1] = rgbps_curve(word[CMD_GRN_LSB +: 3],
                                     ctrl_reg[CTRL_CURVE_BIT]);
        target_next[2] = rgbps_curve(word[CMD_BLU_LSB +: 3],
                                     ctrl_reg[CTRL_CURVE_BIT]);
      end
    end
    if (!run)
    begin
      state_next = SEQ_IDLE;
      led_next   = '{default: 7'h00};
    end
    busy_next = (state_next == SEQ_RUN);  // Flopped so the pin has no decode.
  end

  // Sequencer registers.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg     <= SEQ_IDLE;
      ptr_reg       <= 3'h0;
      run_prev_reg  <= 1'b0;
      start_reg     <= 1'b0;
      step_code_reg <= 4'h0;
      fade_code_reg <= 3'h0;
      shadow_reg    <= '{default: 16'h0000};
      prev_reg      <= '{default: 7'h00};
      target_reg    <= '{default: 7'h00};
      led_reg       <= '{default: 7'h00};
      busy_reg      <= 1'b0;
    end
    else if (ce)
    begin
      state_reg     <= state_next;
      ptr_reg       <= ptr_next;
      run_prev_reg  <= run_prev_next;
      start_reg     <= start_next;
      step_code_reg <= step_code_next;
      fade_code_reg <= fade_code_next;
      shadow_reg    <= shadow_next;
      prev_reg      <= prev_next;
      target_reg    <= target_next;
      led_reg       <= led_next;
      busy_reg      <= busy_next;
    end
  end

  // Outputs are the flip-flops themselves.
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign red_pct   = led_reg[0];
  assign green_pct = led_reg[1];
  assign blue_pct  = led_reg[2];
  assign seq_busy  = busy_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);
  run_off_a: assert property (!run |=> state_reg == SEQ_IDLE &&
      led_reg[0] == 7'h00 && led_reg[2] == 7'h00)
    else $error("sequencer not idle and dark with run low");
  start_first_a: assert property (state_reg == SEQ_IDLE && start_evt &&
      fresh_word[0] != 16'h0000 |=> state_reg == SEQ_RUN &&
      ptr_reg == 3'h0 && start_reg ##1 !start_reg)
    else $error("run rise did not start command 1");
  wrap_first_a: assert property (state_reg == SEQ_RUN && run &&
      tmr.step_done && !start_reg && ptr_reg == 3'h7 &&
      ctrl_reg[CTRL_LOOP_BIT] && fresh_word[0] != 16'h0000
      |=> ptr_reg == 3'h0 && start_reg && state_reg == SEQ_RUN)
    else $error("repeat did not wrap to command 1");
  single_end_a: assert property (state_reg == SEQ_RUN && run &&
      tmr.step_done && !start_reg && ptr_reg == 3'h7 &&
      !ctrl_reg[CTRL_LOOP_BIT] |=> state_reg == SEQ_DONE)
    else $error("single pass did not stop after command 8");
  zero_end_a: assert property (state_reg == SEQ_RUN && run &&
      tmr.step_done && !start_reg && ptr_reg != 3'h7 &&
      shadow_reg[ptr_reg + 3'h1] == 16'h0000 && !ctrl_reg[CTRL_LOOP_BIT]
      |=> state_reg == SEQ_DONE && $stable(ptr_reg))
    else $error("single pass did not stop at an empty command");
  hold_last_a: assert property (state_reg == SEQ_DONE && run |=>
      $stable(led_reg[0]) && $stable(led_reg[1]) && $stable(led_reg[2]))
    else $error("finished pass changed its brightness");
  ignore_write_a: assert property (state_reg == SEQ_DONE && run &&
      wr_done && is_cmd(idx) |=> state_reg == SEQ_DONE ##1
      $stable(led_reg[1]))
    else $error("command write disturbed a finished pass");
  curve_load_a: assert property (start_reg |->
      target_reg[1] == rgbps_curve(shadow_reg[ptr_reg][CMD_GRN_LSB +: 3],
                                   $past(ctrl_reg[CTRL_CURVE_BIT])))
    else $error("target level not taken from the selected curve");
  fade_end_a: assert property (state_reg == SEQ_RUN && run &&
      !start_reg && tmr.phase == PHASE_FULL |=>
      led_reg[0] == $past(target_reg[0]))
    else $error("completed fade did not reach the target");

  run_pass_c: cover property (state_reg == SEQ_RUN ##1 state_reg == SEQ_DONE);
  wrap_c: cover property (state_reg == SEQ_RUN && ptr_reg == 3'h7 ##1
      start_reg && ptr_reg == 3'h0);
  short_step_c: cover property (state_reg == SEQ_RUN && tmr.step_done &&
      tmr.phase != PHASE_FULL);

endmodule : rgbps_top

/* File: tb/rgbps_host.sv */
// Host model that drives the APB port of the sequencer.
`timescale 1ns/10ps
module rgbps_host (
  // Clock.
  input  wire logic        clk,
  // APB master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ==========================================================================
  // Bus cycle
  // ==========================================================================
  // The bus rests idle until the first transfer.
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // One transfer; the request is held until pready is seen at an edge.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] rd,
                      output logic err, output logic tmo);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Bounded wait, so a dead slave cannot hang the run.
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!pready && n < 50);
    rd  = prdata;
    err = pslverr;
    tmo = !pready;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rgbps_host

/* File: tb/tb_top.sv */
// Self-checking bench of the RGB pattern sequencer.
`timescale 1ns/10ps
module tb_top;
  import rgbps_pkg::*;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, seq_busy;
  logic        err, tmo, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rgbps_pct_t  red_pct, green_pct, blue_pct;
  logic [15:0] cmd [8];
  int          n_errors, checks_done;

  rgbps_top #(.CYC_PER_MS(2)) dut_u (.clk(clk), .srst(srst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .red_pct(red_pct), .green_pct(green_pct), .blue_pct(blue_pct),
    .seq_busy(seq_busy));
  rgbps_host host_u (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Free-running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Transfer with an expected error flag; a hung bus ends the run.
  task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d,
                    input logic e);
    host_u.xfer(w, a, d, rd, err, tmo);
    check({31'h0, err}, {31'h0, e});
    if (tmo)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask : xf

  // Model: LED word expected for command k on curve c.
  function automatic logic [31:0] led(input int k, input logic c);
    logic [15:0] w;
    w = cmd[k];
    return c ? {11'h0, CURVE1[w[15:13]], CURVE1[w[12:10]], CURVE1[w[5:3]]}
             : {11'h0, CURVE0[w[15:13]], CURVE0[w[12:10]], CURVE0[w[5:3]]};
  endfunction : led

  // Waits t cycles, then compares LEDs with command k and the busy flag.
  task automatic see(input int t, input int k, input logic c,
                     input logic b);
    repeat (t) @(posedge clk);
    check({11'h0, red_pct, green_pct, blue_pct}, led(k, c));
    check({31'h0, seq_busy}, {31'h0, b});
  endtask : see

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  // A code 0 step with its load takes 396 cycles; samples fall mid-step.
  initial
  begin
    void'($urandom(32'h5503d9a8));
    srst = 1'b1;
    ce = 1'b1;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    xf(1'b0, 12'h044, 8'h00, 1'b0);
    check(rd, 32'h0);
    xf(1'b0, 12'h3fc, 8'h00, 1'b1);
    // Two random commands, step and fade code 0, third one empty.
    for (int k = 0; k < 8; k++)
    begin
      cmd[k] = (k < 2) ? (16'($urandom) & 16'hfc38) | 16'h2000 : 16'h0;
      xf(1'b1, 12'(12'h140 + 8 * k), cmd[k][15:8], 1'b0);
      xf(1'b1, 12'(12'h144 + 8 * k), cmd[k][7:0], 1'b0);
    end
    xf(1'b1, 12'h044, 8'h04, 1'b0);
    see(200, 0, 1'b0, 1'b1);
    see(400, 1, 1'b0, 1'b1);
    see(400, 1, 1'b0, 1'b0);
    xf(1'b0, 12'h080, 8'h00, 1'b0);
    check(rd, 32'h9);
    xf(1'b1, 12'h14c, 8'h38, 1'b0);
    see(400, 1, 1'b0, 1'b0);
    cmd[1][7:0] = 8'h38;
    xf(1'b1, 12'h044, 8'h00, 1'b0);
    xf(1'b1, 12'h044, 8'h07, 1'b0);
    see(200, 0, 1'b1, 1'b1);
    see(400, 1, 1'b1, 1'b1);
    see(400, 0, 1'b1, 1'b1);
    xf(1'b0, 12'h044, 8'h00, 1'b0);
    check(rd, 32'h7);
    xf(1'b1, 12'h044, 8'h00, 1'b0);
    repeat (3) @(posedge clk);
    check({11'h0, red_pct, green_pct, blue_pct}, 32'h0);
    check({31'h0, seq_busy}, 32'h0);
    // Eight random commands, fade code 0 or 1, looped; a freeze of 300
    // cycles inside command 1 must push every later step back by 300.
    for (int k = 0; k < 8; k++)
    begin
      cmd[k] = (16'($urandom) & 16'hfc39) | 16'h2000;
      xf(1'b1, 12'(12'h140 + 8 * k), cmd[k][15:8], 1'b0);
      xf(1'b1, 12'(12'h144 + 8 * k), cmd[k][7:0], 1'b0);
    end
    xf(1'b1, 12'h044, 8'h06, 1'b0);
    see(200, 0, 1'b0, 1'b1);
    ce <= 1'b0;
    see(300, 0, 1'b0, 1'b1);
    ce <= 1'b1;
    for (int k = 1; k <= 8; k++)
      see(396, k % 8, 1'b0, 1'b1);
    xf(1'b1, 12'h044, 8'h04, 1'b0);
    see(3100, 7, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule : tb_top
